// *** mec_consts.svh ***
`ifndef MEC_CONSTS_SVH
`define MEC_CONSTS_SVH

// ==========================================================
// register offsets
`define MEC_ADDR_CTRL3 8'h5d
`define MEC_ADDR_INT_SRC 8'h5e
`define MEC_ADDR_VECM_CFG 8'h69
`define MEC_ADDR_VECM_THS_MSB 8'h6a
`define MEC_ADDR_VECM_THS_LSB 8'h6b
`define MEC_ADDR_VECM_CNT 8'h6c
`define MEC_ADDR_VECM_INIT_FIRST 8'h6d
`define MEC_ADDR_VECM_INIT_LAST 8'h72

// ==========================================================
// field positions
`define MEC_CTRL3_RAW 7
`define MEC_CTRL3_SLP_OS_HI 6
`define MEC_CTRL3_SLP_OS_LO 4
`define MEC_CTRL3_THS_UPD 3
`define MEC_CTRL3_ST_Z 2
`define MEC_CTRL3_ST_XY_HI 1
`define MEC_CTRL3_ST_XY_LO 0
`define MEC_SRC_THS 2
`define MEC_SRC_VECM 1
`define MEC_SRC_DRDY 0
`define MEC_VCFG_ELE 6
`define MEC_VCFG_INITM 5
`define MEC_VCFG_UPDM 4
`define MEC_VCFG_EN 3
`define MEC_VCFG_USED_MASK 8'h7f
`define MEC_THS_DBCNTM 7

// ==========================================================
// reset values and limits
`define MEC_RST_REG 8'h00
`define MEC_OSR_MIN_EXP 1
`define MEC_SAT_POS 17'sh07fff
`define MEC_SAT_NEG 17'sh18000

`endif

// *** mec_host_model.sv ***
// ==========================================================
// host on the register port: one strobe per access
module mec_host_model (
   input wire logic i_ref_clk,
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = 18'h0;
   end
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = {a, d, w, !w};
      @(negedge i_ref_clk);
      // released lines never keep the last value
      {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = {~a, ~d, 2'b00};
   endtask
endmodule

// *** mec_mag_event.sv ***
`include "mec_consts.svh"
// What this block does
// - raw bit clear: stored hard-iron offsets are subtracted from every sample.
// - raw bit set: samples pass through without offset correction.
// - auto-sleep state uses its own three-bit oversample code.
// - update-select clear: threshold trigger on any axis refreshes all three references.
// - update-select set: only the triggering axis reference is refreshed.
// - Z self-test enable bit drives the Z self-test excitation.
// - any nonzero XY self-test field enables X and Y self-test together.
// - oversample code and output rate map to a fixed oversample count.
// - threshold flag at bit 2 set on a threshold event.
// - vector-magnitude flag at bit 1 set on a vector-magnitude event.
// - data-ready flag at bit 0 on new samples; bits 7..3 read zero.
// - event needs distance above threshold persisting beyond the debounce count.
// - current vector is the decimated output, compared against latched references.
// - zero references give absolute magnitude threshold, else change detection.
// - vector-magnitude references are internal and never readable.
// - threshold is fifteen unsigned bits, 0.1 uT per step.
// - latched flag clears only on source read; unlatched follows detector.
// - enabling loads references from current output or initial-value registers.
module mec_mag_event (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   input wire logic [2:0] i_rate_sel,
   input wire logic i_auto_sleep,
   input wire logic [2:0] i_normal_os_code,
   input wire logic i_sample_valid,
   input wire logic signed [15:0] i_raw_x,
   input wire logic signed [15:0] i_raw_y,
   input wire logic signed [15:0] i_raw_z,
   input wire logic signed [15:0] i_off_x,
   input wire logic signed [15:0] i_off_y,
   input wire logic signed [15:0] i_off_z,
   input wire logic i_ths_event,
   input wire logic [2:0] i_ths_axis,
   output logic signed [15:0] o_mag_x,
   output logic signed [15:0] o_mag_y,
   output logic signed [15:0] o_mag_z,
   output logic o_mag_valid,
   output logic [10:0] o_oversample_count,
   output logic [2:0] o_ths_ref_load,
   output logic o_z_selftest_enable,
   output logic o_xy_selftest_enable,
   output logic o_vecm_event
);
   // ==========================================================
   // helpers
   function automatic mec_pkg::mec_sample_t sat_sub(input mec_pkg::mec_sample_t a, input mec_pkg::mec_sample_t b);
      logic signed [16:0] d;
      d = 17'(a) - 17'(b);
      if (d > `MEC_SAT_POS) begin
         return 16'sh7fff;
      end else if (d < `MEC_SAT_NEG) begin
         return 16'sh8000;
      end
      return d[15:0];
   endfunction

   // rate index 0..7 = 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
   function automatic logic [3:0] osr_exp(input logic [2:0] rate, input logic [2:0] os);
      int k;
      int e;
      k = 0;
      case (rate)
         3'h0: k = -7;
         3'h1: k = -5;
         3'h2: k = -4;
         3'h3: k = -3;
         3'h4: k = -2;
         3'h5: k = 0;
         3'h6: k = 1;
         default: k = 3;
      endcase
      e = ((os == 3'h0) ? 1 : int'(os)) + k;
      if (e < `MEC_OSR_MIN_EXP) begin
         e = `MEC_OSR_MIN_EXP;
      end
      return 4'(e);
   endfunction

   // ==========================================================
   // registers
   logic [7:0] ctrl3_r;
   logic [7:0] vcfg_r;
   logic [7:0] ths_msb_r;
   logic [7:0] ths_lsb_r;
   logic [7:0] cnt_r;
   logic [7:0] init_r [0:5];
   logic ths_flag_r;
   logic vecm_flag_r;
   logic drdy_flag_r;

   logic hit_ctrl3;
   logic hit_src;
   logic hit_vcfg;
   logic hit_ths_msb;
   logic hit_ths_lsb;
   logic hit_cnt;
   logic hit_init;
   logic [2:0] init_idx;
   logic src_rd;
   logic [7:0] src_val;
   logic [7:0] rdata_nxt;

   assign hit_ctrl3 = i_reg_addr == `MEC_ADDR_CTRL3;
   assign hit_src = i_reg_addr == `MEC_ADDR_INT_SRC;
   assign hit_vcfg = i_reg_addr == `MEC_ADDR_VECM_CFG;
   assign hit_ths_msb = i_reg_addr == `MEC_ADDR_VECM_THS_MSB;
   assign hit_ths_lsb = i_reg_addr == `MEC_ADDR_VECM_THS_LSB;
   assign hit_cnt = i_reg_addr == `MEC_ADDR_VECM_CNT;
   assign hit_init = (i_reg_addr >= `MEC_ADDR_VECM_INIT_FIRST) && (i_reg_addr <= `MEC_ADDR_VECM_INIT_LAST);
   assign init_idx = 3'(i_reg_addr - `MEC_ADDR_VECM_INIT_FIRST);
   assign src_rd = i_reg_rd && hit_src;
   assign src_val = {5'h00, ths_flag_r, vecm_flag_r, drdy_flag_r};

   // references have no address, so they can never be read back
   assign rdata_nxt = hit_ctrl3 ? ctrl3_r :
                      hit_src ? src_val :
                      hit_vcfg ? (vcfg_r & `MEC_VCFG_USED_MASK) :
                      hit_ths_msb ? ths_msb_r :
                      hit_ths_lsb ? ths_lsb_r :
                      hit_cnt ? cnt_r :
                      hit_init ? init_r[init_idx] :
                      8'h00;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ctrl3_r <= `MEC_RST_REG;
         vcfg_r <= `MEC_RST_REG;
         ths_msb_r <= `MEC_RST_REG;
         ths_lsb_r <= `MEC_RST_REG;
         cnt_r <= `MEC_RST_REG;
         for (int i = 0; i < 6; i++) begin
            init_r[i] <= `MEC_RST_REG;
         end
      end else if (i_reg_wr) begin
         if (hit_ctrl3) ctrl3_r <= i_reg_wdata;
         if (hit_vcfg) vcfg_r <= i_reg_wdata & `MEC_VCFG_USED_MASK;
         if (hit_ths_msb) ths_msb_r <= i_reg_wdata;
         if (hit_ths_lsb) ths_lsb_r <= i_reg_wdata;
         if (hit_cnt) cnt_r <= i_reg_wdata;
         if (hit_init) init_r[init_idx] <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= rdata_nxt;
      end
   end

   // ==========================================================
   // control fields
   logic raw_mode;
   logic ths_upd_axis;
   logic [2:0] slp_os_code;
   logic vm_ele;
   logic vm_initm;
   logic vm_updm;
   logic vm_en;
   logic dbc_clear_mode;
   logic [14:0] vm_ths;
   mec_pkg::mec_sample_t init_x;
   mec_pkg::mec_sample_t init_y;
   mec_pkg::mec_sample_t init_z;

   assign raw_mode = ctrl3_r[`MEC_CTRL3_RAW];
   assign ths_upd_axis = ctrl3_r[`MEC_CTRL3_THS_UPD];
   assign slp_os_code = ctrl3_r[`MEC_CTRL3_SLP_OS_HI:`MEC_CTRL3_SLP_OS_LO];
   assign vm_ele = vcfg_r[`MEC_VCFG_ELE];
   assign vm_initm = vcfg_r[`MEC_VCFG_INITM];
   assign vm_updm = vcfg_r[`MEC_VCFG_UPDM];
   assign vm_en = vcfg_r[`MEC_VCFG_EN];
   assign dbc_clear_mode = ths_msb_r[`MEC_THS_DBCNTM];
   assign vm_ths = {ths_msb_r[6:0], ths_lsb_r};
   assign init_x = {init_r[0], init_r[1]};
   assign init_y = {init_r[2], init_r[3]};
   assign init_z = {init_r[4], init_r[5]};

   // ==========================================================
   // sample path, oversample count, self-test, threshold references
   logic [2:0] os_code;
   logic [10:0] os_count_nxt;
   logic [2:0] ths_load_nxt;

   assign os_code = i_auto_sleep ? slp_os_code : i_normal_os_code;
   assign os_count_nxt = 11'h001 << osr_exp(i_rate_sel, os_code);
   assign ths_load_nxt = !i_ths_event ? 3'h0 : (ths_upd_axis ? i_ths_axis : 3'h7);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_mag_x <= 16'sh0000;
         o_mag_y <= 16'sh0000;
         o_mag_z <= 16'sh0000;
         o_mag_valid <= 1'b0;
      end else begin
         o_mag_valid <= i_sample_valid;
         if (i_sample_valid) begin
            o_mag_x <= raw_mode ? i_raw_x : sat_sub(i_raw_x, i_off_x);
            o_mag_y <= raw_mode ? i_raw_y : sat_sub(i_raw_y, i_off_y);
            o_mag_z <= raw_mode ? i_raw_z : sat_sub(i_raw_z, i_off_z);
         end
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_oversample_count <= 11'h000;
         o_ths_ref_load <= 3'h0;
         o_z_selftest_enable <= 1'b0;
         o_xy_selftest_enable <= 1'b0;
      end else begin
         o_oversample_count <= os_count_nxt;
         o_ths_ref_load <= ths_load_nxt;
         o_z_selftest_enable <= ctrl3_r[`MEC_CTRL3_ST_Z];
         o_xy_selftest_enable <= |ctrl3_r[`MEC_CTRL3_ST_XY_HI:`MEC_CTRL3_ST_XY_LO];
      end
   end

   // ==========================================================
   // vector-magnitude detector
   mec_pkg::mec_vm_state_t vm_state_r;
   mec_pkg::mec_vm_state_t vm_state_nxt;
   mec_pkg::mec_sample_t ref_x_r;
   mec_pkg::mec_sample_t ref_y_r;
   mec_pkg::mec_sample_t ref_z_r;
   logic [7:0] dbc_r;
   logic [7:0] dbc_nxt;
   logic vm_active_r;
   logic vm_active_nxt;
   logic dist_valid;
   logic dist_above;
   logic vm_trig;
   logic vm_start;
   logic ref_from_init;
   logic ref_from_out;

   // current vector is the output the host also sees, offset-corrected only while the raw bit is clear
   mec_vecm_dist #(
      .DW(16),
      .TW(15)
   ) u_dist (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_valid(o_mag_valid),
      .i_cur_x(o_mag_x),
      .i_cur_y(o_mag_y),
      .i_cur_z(o_mag_z),
      .i_ref_x(ref_x_r),
      .i_ref_y(ref_y_r),
      .i_ref_z(ref_z_r),
      .i_ths(vm_ths),
      .o_valid(dist_valid),
      .o_above(dist_above)
   );

   assign vm_state_nxt = vm_en ? mec_pkg::MEC_VM_RUN : mec_pkg::MEC_VM_OFF;
   assign vm_start = vm_en && (vm_state_r == mec_pkg::MEC_VM_OFF);
   // initm and updm both set lets software steer the references live
   assign ref_from_init = (vm_start && vm_initm) ||
                          (vm_state_r == mec_pkg::MEC_VM_RUN && vm_en && vm_initm && vm_updm);
   assign ref_from_out = (vm_start && !vm_initm) || (vm_trig && !vm_updm);

   // debounce advances once per sample (each valid distance result), not once per clock
   always_comb begin
      dbc_nxt = dbc_r;
      vm_active_nxt = vm_active_r;
      case (vm_state_r)
         mec_pkg::MEC_VM_RUN: begin
            if (!vm_en) begin
               dbc_nxt = 8'h00;
               vm_active_nxt = 1'b0;
            end else if (dist_valid && dist_above) begin
               if (dbc_r >= cnt_r) begin
                  vm_active_nxt = 1'b1;
               end else begin
                  dbc_nxt = dbc_r + 8'h01;
               end
            end else if (dist_valid) begin
               vm_active_nxt = 1'b0;
               if (dbc_clear_mode) begin
                  dbc_nxt = 8'h00;
               end else if (dbc_r != 8'h00) begin
                  dbc_nxt = dbc_r - 8'h01;
               end
            end
         end
         default: begin
            dbc_nxt = 8'h00;
            vm_active_nxt = 1'b0;
         end
      endcase
   end

   assign vm_trig = vm_active_nxt && !vm_active_r;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         vm_state_r <= mec_pkg::MEC_VM_OFF;
         dbc_r <= 8'h00;
         vm_active_r <= 1'b0;
      end else begin
         vm_state_r <= vm_state_nxt;
         dbc_r <= dbc_nxt;
         vm_active_r <= vm_active_nxt;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ref_x_r <= 16'sh0000;
         ref_y_r <= 16'sh0000;
         ref_z_r <= 16'sh0000;
      end else if (ref_from_init) begin
         ref_x_r <= init_x;
         ref_y_r <= init_y;
         ref_z_r <= init_z;
      end else if (ref_from_out) begin
         ref_x_r <= o_mag_x;
         ref_y_r <= o_mag_y;
         ref_z_r <= o_mag_z;
      end
   end

   // ==========================================================
   // source flags: a new event in the read cycle survives the clear
   logic ths_flag_nxt;
   logic vecm_flag_nxt;
   logic drdy_flag_nxt;

   assign ths_flag_nxt = i_ths_event || (ths_flag_r && !src_rd);
   assign vecm_flag_nxt = vm_ele ? (vm_trig || (vecm_flag_r && !src_rd)) : vm_active_nxt;
   assign drdy_flag_nxt = o_mag_valid || (drdy_flag_r && !src_rd);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ths_flag_r <= 1'b0;
         vecm_flag_r <= 1'b0;
         drdy_flag_r <= 1'b0;
         o_vecm_event <= 1'b0;
      end else begin
         ths_flag_r <= ths_flag_nxt;
         vecm_flag_r <= vecm_flag_nxt;
         drdy_flag_r <= drdy_flag_nxt;
         o_vecm_event <= vecm_flag_nxt;
      end
   end
endmodule

// *** mec_mag_event_chk.sv ***
`include "mec_consts.svh"
// ==========================================================
// port checker
module mec_mag_event_chk (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [2:0] i_rate_sel,
   input wire logic i_auto_sleep,
   input wire logic [2:0] i_normal_os_code,
   input wire logic i_sample_valid,
   input wire logic signed [15:0] i_raw_x,
   input wire logic signed [15:0] i_off_x,
   input wire logic i_ths_event,
   input wire logic [2:0] i_ths_axis,
   input wire logic signed [15:0] o_mag_x,
   input wire logic [10:0] o_oversample_count,
   input wire logic [2:0] o_ths_ref_load,
   input wire logic o_z_selftest_enable,
   input wire logic o_xy_selftest_enable,
   input wire logic o_vecm_event
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   logic [7:0] c3_r;
   logic signed [16:0] dx;
   logic ok_x;
   logic src_rd;
   logic [2:0] os_code;
   logic [10:0] os_exp;
   function automatic logic [10:0] os_cnt(input logic [2:0] r, input logic [2:0] c);
      int e;
      e = (c == 3'h0) ? 1 : int'(c);
      case (r)
         3'h7: e = e + 3;
         3'h6: e = e + 1;
         3'h5: e = e;
         default: e = e + int'(r) - 6;
      endcase
      if (e < 1) e = 1;
      return 11'(1 << e);
   endfunction
   // ==========================================================
   // shadow of the control register, written like the device
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) c3_r <= 8'h00;
      else if (i_reg_wr && i_reg_addr == `MEC_ADDR_CTRL3) c3_r <= i_reg_wdata;
   end
   assign dx = i_raw_x - i_off_x;
   assign ok_x = (dx[16] == dx[15]);
   assign src_rd = i_reg_rd && i_reg_addr == `MEC_ADDR_INT_SRC;
   assign os_code = i_auto_sleep ? c3_r[6:4] : i_normal_os_code;
   assign os_exp = os_cnt(i_rate_sel, os_code);
   // ==========================================================
   // assertions
   chk_raw_pass: assert property (i_sample_valid && c3_r[7] |=> o_mag_x == $past(i_raw_x))
      else $error("raw sample altered");
   chk_offset_sub: assert property (i_sample_valid && !c3_r[7] && ok_x |=> o_mag_x == $past(dx[15:0]))
      else $error("offset not applied");
   chk_src_upper: assert property (src_rd |=> o_reg_rdata[7:3] == 5'h00)
      else $error("source upper bits set");
   // a read in between would clear the flag legally
   chk_ths_flag: assert property (i_ths_event ##1 !src_rd ##1 src_rd |=> o_reg_rdata[`MEC_SRC_THS])
      else $error("threshold flag missing");
   chk_vecm_src: assert property (src_rd |=> o_reg_rdata[`MEC_SRC_VECM] == $past(o_vecm_event))
      else $error("vecm flag differs");
   chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved");
   chk_ref_load: assert property (i_ths_event |=>
      o_ths_ref_load == ($past(c3_r[3]) ? $past(i_ths_axis) : 3'b111))
      else $error("wrong reference load");
   chk_ref_idle: assert property (!i_ths_event |=> o_ths_ref_load == 3'b000)
      else $error("spurious reference load");
   chk_z_selftest: assert property (o_z_selftest_enable == $past(c3_r[2]))
      else $error("z self-test wrong");
   chk_xy_selftest: assert property (o_xy_selftest_enable == $past(|c3_r[1:0]))
      else $error("xy self-test wrong");
   chk_os_count: assert property (!$past(i_rst) |-> o_oversample_count == $past(os_exp))
      else $error("oversample count wrong");
   cover property (o_vecm_event);
   cover property (i_ths_event && c3_r[3]);
   cover property (i_sample_valid && !c3_r[7] && !ok_x);
endmodule

bind mec_mag_event mec_mag_event_chk u_chk (.*);

// *** mec_mag_event_tb.sv ***
`include "mec_consts.svh"
module mec_mag_event_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_auto_sleep, i_sample_valid, i_ths_event;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [2:0] i_rate_sel, i_normal_os_code, i_ths_axis, o_ths_ref_load;
   logic signed [15:0] i_raw_x, i_raw_y, i_raw_z, i_off_x, i_off_y, i_off_z, o_mag_x, o_mag_y, o_mag_z;
   logic o_mag_valid, o_z_selftest_enable, o_xy_selftest_enable, o_vecm_event, rd_seen, rawb;
   logic [10:0] o_oversample_count;
   logic [31:0] s, t;
   logic [15:0] rd_note;
   logic [15:0] q_rd[$];
   logic [47:0] q_mag[$];
   int n_errors = 0;
   int checks = 0;
   mec_mag_event dut (.*);
   mec_host_model host (.i_ref_clk(i_ref_clk), .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
      .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));
   initial begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = ~i_ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [15:0] corr(input logic [15:0] r, input logic [15:0] o);
      logic signed [16:0] d;
      d = $signed({r[15], r}) - $signed({o[15], o});
      if (rawb) return r;
      if (d > `MEC_SAT_POS) return 16'h7fff;
      if (d < `MEC_SAT_NEG) return 16'h8000;
      return d[15:0];
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      if (n_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.access(1'b1, a, d);
   endtask
   // mask selects the bits that are known at read time
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      q_rd.push_back({m, e});
      host.access(1'b0, a, 8'h00);
   endtask
   task automatic smp(input logic [15:0] x, y, z, ox, oy, oz);
      @(negedge i_ref_clk);
      {i_raw_x, i_raw_y, i_raw_z, i_off_x, i_off_y, i_off_z} = {x, y, z, ox, oy, oz};
      i_sample_valid = 1'b1;
      q_mag.push_back({corr(x, ox), corr(y, oy), corr(z, oz)});
      @(negedge i_ref_clk);
      i_sample_valid = 1'b0;
      {i_raw_x, i_raw_y, i_raw_z} = ~{x, y, z};
      repeat (4) @(negedge i_ref_clk);
   endtask
   // ==========================================================
   // output watcher
   always @(posedge i_ref_clk) rd_seen <= i_reg_rd;
   always @(negedge i_ref_clk) begin
      if (o_mag_valid === 1'b1) check({o_mag_x, o_mag_y, o_mag_z}, q_mag.pop_front());
      if (rd_seen === 1'b1) begin
         rd_note = q_rd.pop_front();
         check({40'h0, o_reg_rdata & rd_note[15:8]}, {40'h0, rd_note[7:0]});
      end
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      n_errors++;
      end_sim();
   end
   // ==========================================================
   // main sequence
   initial begin
      i_rst = 1'b1;
      {i_rate_sel, i_normal_os_code, i_ths_axis, i_auto_sleep, i_sample_valid, i_ths_event} = 12'h0;
      {i_raw_x, i_raw_y, i_raw_z, i_off_x, i_off_y, i_off_z} = 96'h0;
      rawb = 1'b0;
      s = 32'hd9cccf10;
      repeat (12) @(negedge i_ref_clk);
      i_rst = 1'b0;
      rd(8'h5d, 8'hff, 8'h00);
      rd(8'h5e, 8'hff, 8'h00);
      rd(8'h7f, 8'hff, 8'h00);
      wr(8'h5e, 8'hff);
      rd(8'h5e, 8'hff, 8'h00);
      wr(8'h69, 8'h87);
      rd(8'h69, 8'hff, 8'h07);
      // random rate, code, sleep state and threshold triggers
      for (int i = 0; i < 256; i++) begin
         if (i % 32 == 0) wr(8'h5d, s[7:0]);
         @(negedge i_ref_clk);
         s = lfsr(s);
         {i_ths_axis, i_ths_event, i_auto_sleep, i_normal_os_code, i_rate_sel} = s[10:0];
      end
      @(negedge i_ref_clk);
      i_ths_event = 1'b0;
      wr(8'h5d, 8'h80);
      rd(8'h5e, 8'h00, 8'h00);
      i_ths_event = 1'b1;
      @(negedge i_ref_clk);
      i_ths_event = 1'b0;
      rd(8'h5e, 8'hff, 8'h04);
      rd(8'h5e, 8'hff, 8'h00);
      for (int r = 0; r < 2; r++) begin
         rawb = r[0];
         wr(8'h5d, {rawb, 7'h00});
         smp(16'h7fff, 16'h0001, 16'h8000, 16'h8000, 16'h7fff, 16'h0001);
         repeat (4) begin
            s = lfsr(s);
            t = lfsr(s);
            s = lfsr(t);
            smp(s[15:0], s[31:16], t[15:0], t[31:16], s[23:8], t[23:8]);
         end
      end
      rd(8'h5e, 8'h01, 8'h01);
      // threshold 100, debounce 2, latched, refs from zero init values
      wr(8'h6a, 8'h00);
      wr(8'h6b, 8'h64);
      wr(8'h6c, 8'h02);
      wr(8'h69, 8'h68);
      smp(16'd100, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      repeat (2) smp(16'd200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h0);
      smp(16'd200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h1);
      smp(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h1);
      rd(8'h5e, 8'h02, 8'h02);
      rd(8'h5e, 8'h02, 8'h00);
      // nonzero references: small change from 1000 must stay quiet
      wr(8'h6d, 8'h03);
      wr(8'h6e, 8'he8);
      wr(8'h69, 8'h00);
      wr(8'h69, 8'h68);
      repeat (3) smp(16'd1050, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h0);
      // refs taken from the output (1050), unlatched flag, debounce cleared below threshold
      wr(8'h6a, 8'h80);
      wr(8'h69, 8'h00);
      wr(8'h69, 8'h08);
      repeat (3) smp(16'd1120, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h0);
      repeat (3) smp(16'd1200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h1);
      smp(16'd1200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h0);
      repeat (2) smp(16'd1400, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
      check({47'h0, o_vecm_event}, 48'h0);
      end_sim();
   end
endmodule

// *** mec_pkg.sv ***
package mec_pkg;
   typedef enum logic [0:0] {
      MEC_VM_OFF,
      MEC_VM_RUN
   } mec_vm_state_t;

   typedef logic signed [15:0] mec_sample_t;
endpackage

// *** mec_vecm_dist.sv ***
// ==========================================================
// squared distance against squared threshold, one cycle latency
module mec_vecm_dist #(
   parameter int DW = 16,
   parameter int TW = 15
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_valid,
   input wire logic signed [DW-1:0] i_cur_x,
   input wire logic signed [DW-1:0] i_cur_y,
   input wire logic signed [DW-1:0] i_cur_z,
   input wire logic signed [DW-1:0] i_ref_x,
   input wire logic signed [DW-1:0] i_ref_y,
   input wire logic signed [DW-1:0] i_ref_z,
   input wire logic [TW-1:0] i_ths,
   output logic o_valid,
   output logic o_above
);
   // squares avoid a root; both sides are non-negative so order is kept
   logic signed [DW:0] dx;
   logic signed [DW:0] dy;
   logic signed [DW:0] dz;
   logic [2*DW+1:0] sx;
   logic [2*DW+1:0] sy;
   logic [2*DW+1:0] sz;
   logic [2*DW+3:0] ssum;
   logic [2*TW-1:0] thsq;
   logic above;

   assign dx = (DW+1)'(i_cur_x) - (DW+1)'(i_ref_x);
   assign dy = (DW+1)'(i_cur_y) - (DW+1)'(i_ref_y);
   assign dz = (DW+1)'(i_cur_z) - (DW+1)'(i_ref_z);
   assign sx = (2*DW+2)'(dx * dx);
   assign sy = (2*DW+2)'(dy * dy);
   assign sz = (2*DW+2)'(dz * dz);
   assign ssum = (2*DW+4)'(sx) + (2*DW+4)'(sy) + (2*DW+4)'(sz);
   assign thsq = (2*TW)'(i_ths) * (2*TW)'(i_ths);
   assign above = ssum > (2*DW+4)'(thsq);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_above <= 1'b0;
      end else begin
         o_valid <= i_valid;
         o_above <= above;
      end
   end
endmodule
